//--- pkg/flash_erase_pkg.sv
package flash_erase_pkg;

	// Byte offsets of the registers on the bus.
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_KEY = 5'h04;
	localparam logic [4:0] OFS_ADDR = 5'h08;
	localparam logic [4:0] OFS_DATA = 5'h0C;

	// Field positions in the control register.
	localparam int unsigned BIT_GO = 0;
	localparam int unsigned BIT_PROG_EN = 1;
	localparam int unsigned BIT_ROW_ERASE = 2;
	localparam int unsigned BIT_SPACE = 3;
	localparam int unsigned BIT_DONE = 4;
	localparam int unsigned BIT_IRQ_EN = 5;
	localparam int unsigned BIT_REFUSED = 6;

	// Unlock keys.
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;

	// Array shape.
	localparam int unsigned WORD_W = 14;
	localparam int unsigned PROG_AW = 12;
	localparam int unsigned ID_AW = 2;
	localparam logic [4:0] ROW_LAST = 5'h1F;
	localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3FFF;

	// Address map of both spaces.
	localparam logic [14:0] PROG_LAST = 15'h0FFF;
	localparam logic [14:0] ID_LAST = 15'h0003;
	localparam logic [14:0] REV_ADDR = 15'h0005;
	localparam logic [14:0] DEVID_ADDR = 15'h0006;
	localparam logic [14:0] CFG_FIRST = 15'h0007;
	localparam logic [14:0] CFG_LAST = 15'h000B;
	localparam logic [14:0] INFO_FIRST = 15'h0100;
	localparam logic [14:0] INFO_LAST = 15'h02FF;

	// Identity words; both values are arbitrary.
	localparam logic [WORD_W-1:0] REV_ID_VAL = 14'h0101;
	localparam logic [WORD_W-1:0] DEV_ID_VAL = 14'h0A5A;

	// Reset values.
	localparam logic [14:0] TARGET_RST = 15'h0000;

	// Control bits; done is set by the erase sequencer, the others by software.
	typedef struct packed {
		logic irq_en;
		logic done;
		logic space_sel;
		logic row_erase;
		logic prog_en;
	} ctrl_s;

	localparam ctrl_s CTRL_RST = '{irq_en: 1'b0, done: 1'b0, space_sel: 1'b0,
		row_erase: 1'b0, prog_en: 1'b0};

endpackage : flash_erase_pkg

//--- sim/flash_row_erase_unlock_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// Watches the slave port and the stall line for erase timing.
module flash_erase_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic cpu_stall,
	input wire logic op_done_irq
);
	logic [5:0] scnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Counts the cycles of the running stall.
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			scnt <= '0;
		else
			scnt <= cpu_stall ? scnt + 6'h1 : '0;
	sequence s_rd;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	property p_rd; $rose(avs_read) |-> s_rd; endproperty
	a_rd: assert property (p_rd) else $error("read wait");
	property p_len; $fell(cpu_stall) |-> scnt == 6'h20; endproperty
	a_len: assert property (p_len) else $error("stall len");
	property p_max; cpu_stall |-> scnt < 6'h20; endproperty
	a_max: assert property (p_max) else $error("stall max");
	property p_start; avs_write && $rose(avs_waitrequest) |=> cpu_stall; endproperty
	a_start: assert property (p_start) else $error("no stall");
	property p_wait; cpu_stall |-> avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("bus free");
	property p_end; $fell(cpu_stall) |-> !avs_waitrequest; endproperty
	a_end: assert property (p_end) else $error("end held");
	property p_other; avs_write && avs_address != 5'h00 |-> !avs_waitrequest; endproperty
	a_other: assert property (p_other) else $error("wait");
	property p_cause; $rose(cpu_stall) |-> $past(avs_write) && $past(avs_writedata[0]);
	endproperty
	a_cause: assert property (p_cause) else $error("cause");
	property p_irq; $rose(op_done_irq) |-> $past(cpu_stall) || $past(avs_write); endproperty
	a_irq: assert property (p_irq) else $error("irq");
endmodule : flash_erase_checker
bind flash_row_erase_unlock_ctrl flash_erase_checker flash_erase_checker_i (.core_clk,
	.resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
	.cpu_stall, .op_done_irq);
`default_nettype wire

//--- sim/flash_row_erase_unlock_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
// Drives the controller over its slave port and checks erase results.
module flash_row_erase_unlock_ctrl_test;
	import flash_erase_pkg::*;
	logic core_clk, resetn, avs_read, avs_write, avs_waitrequest, cpu_stall, op_done_irq;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q, v, r, c, seed;
	logic [3:0] avs_byteenable;
	logic [6:0] wp_row_limit;
	logic [14:0] t, ta;
	int err_count, cmp_count, wcnt, scnt, s0, i, j;
	flash_row_erase_unlock_ctrl flash_row_erase_unlock_ctrl_i (.core_clk, .resetn,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .wp_row_limit, .cpu_stall, .op_done_irq);
	always #5 core_clk = ~core_clk;
	// Counts stalled cycles.
	always @(posedge core_clk) if (cpu_stall) scnt++;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task chk(input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	// One bus cycle, held until waitrequest is sampled low at a rising edge; read data are taken there.
	task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		wcnt = 0;
		do
		begin
			@(posedge core_clk);
			wcnt++;
		end
		while (avs_waitrequest);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask : xfer
	// Full erase request: target, mode bits, both keys and the go bit with nothing in between.
	task automatic go(input logic [14:0] a, input logic [31:0] k);
		xfer(0, OFS_ADDR, {17'h0, a});
		xfer(0, OFS_CTRL, k);
		xfer(0, OFS_KEY, 32'h0000_0055);
		xfer(0, OFS_KEY, 32'h0000_00AA);
		xfer(0, OFS_CTRL, k | 32'h0000_0001);
	endtask : go
	task print_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		print_verdict;
	end
	initial
	begin
		core_clk = 0;
		resetn = 0;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		avs_byteenable = 4'hF;
		wp_row_limit = 0;
		seed = 32'h9d9c_c715;
		err_count = 0;
		cmp_count = 0;
		scnt = 0;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		xfer(1, OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		xfer(1, 5'h10, 32'h0);
		chk(q, 32'h0);
		// Random program rows: erase, then check the row and its neighbour.
		for (i = 0; i < 3; i++)
		begin
			r = rnd();
			t = {3'h0, r[11:0]};
			xfer(0, OFS_ADDR, {17'h0, t ^ 15'h0020});
			xfer(1, OFS_DATA, 32'h0);
			v = q;
			s0 = scnt;
			go(t, 32'h0000_0006);
			chk(32'(wcnt), 32'h0000_0022);
			chk(32'(scnt - s0), 32'h0000_0020);
			xfer(1, OFS_CTRL, 32'h0);
			chk(q, 32'h0000_0016);
			xfer(0, OFS_ADDR, {17'h0, t[14:5], r[20:16]});
			xfer(1, OFS_DATA, 32'h0);
			chk(q, {18'h0, ERASED_WORD});
			xfer(0, OFS_ADDR, {17'h0, t ^ 15'h0020});
			xfer(1, OFS_DATA, 32'h0);
			chk(q, v);
			xfer(0, OFS_CTRL, 32'h0000_0026);
			chk({31'h0, op_done_irq}, 32'h1);
			xfer(0, OFS_CTRL, 32'h0000_0016);
			chk({31'h0, op_done_irq}, 32'h0);
		end
		// Broken handshakes: a foreign write or a wrong key between keys.
		for (j = 0; j < 2; j++)
		begin
			xfer(0, OFS_KEY, 32'h0000_0055);
			xfer(0, j ? OFS_KEY : OFS_ADDR, j ? 32'h0000_00A5 : {17'h0, t});
			xfer(0, OFS_KEY, 32'h0000_00AA);
			xfer(0, OFS_CTRL, 32'h0000_0007);
			chk(32'(wcnt), 32'h1);
			xfer(1, OFS_CTRL, 32'h0);
			chk(q, 32'h0000_0006);
		end
		// Refused goes: no enable, protected row, beyond the map, read-only word.
		t = {4'h0, r[10:0]};
		for (j = 0; j < 4; j++)
		begin
			c = (j == 0) ? 32'h0000_0004 : (j == 3) ? 32'h0000_000E : 32'h0000_0006;
			ta = (j == 2) ? 15'h1000 : (j == 3) ? 15'h0005 : t;
			@(posedge core_clk);
			wp_row_limit <= (j == 1) ? t[11:5] + 7'h01 : 7'h00;
			go(ta, c);
			chk(32'(wcnt), 32'h1);
			xfer(1, OFS_CTRL, 32'h0);
			chk(q, c | 32'h0000_0040);
		end
		go(15'h0002, 32'h0000_000E);
		chk(32'(wcnt), 32'h0000_0022);
		xfer(0, OFS_ADDR, 32'h0);
		xfer(1, OFS_DATA, 32'h0);
		chk(q, {18'h0, ERASED_WORD});
		xfer(1, OFS_CTRL, 32'h0);
		chk(q, 32'h0000_001E);
		xfer(0, OFS_ADDR, {17'h0, REV_ADDR});
		xfer(1, OFS_DATA, 32'h0);
		chk(q, {18'h0, REV_ID_VAL});
		print_verdict;
	end
endmodule : flash_row_erase_unlock_ctrl_test
`default_nettype wire

//--- src/flash_row_erase_unlock_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Unlock handshake, row erase sequencer and address map behind an Avalon-MM slave.
module flash_row_erase_unlock_ctrl (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [6:0] wp_row_limit,
	output logic cpu_stall,
	output logic op_done_irq
);
	import flash_erase_pkg::*;

	typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_KEY2} unlock_e;

	unlock_e unlock;
	unlock_e next_unlock;
	ctrl_s ctrl;
	logic [14:0] target;
	logic [14:0] next_target;
	logic busy;
	logic [4:0] er_cnt;
	logic [6:0] er_row;
	logic er_space;
	logic refused;
	logic rd_wait;
	logic [WORD_W-1:0] prog_rdata;
	logic [WORD_W-1:0] id_rdata;

	// Address decode and byte lanes.
	wire sel_ctrl = avs_address == OFS_CTRL;
	wire sel_key = avs_address == OFS_KEY;
	wire sel_addr = avs_address == OFS_ADDR;
	wire sel_data = avs_address == OFS_DATA;
	wire lane0 = avs_byteenable[0];
	wire lane1 = avs_byteenable[1];
	wire go_req = avs_write & sel_ctrl & lane0 & avs_writedata[BIT_GO];

	// Target checks: program space outside protected rows, or writable words of the other space.
	wire prog_ok = !ctrl.space_sel && target <= PROG_LAST && target[11:5] >= wp_row_limit;
	wire id_ok = ctrl.space_sel && (target <= ID_LAST || (target >= CFG_FIRST && target <= CFG_LAST));
	wire armed = unlock == UL_KEY2 && ctrl.prog_en && ctrl.row_erase;
	wire start = go_req && armed && (prog_ok || id_ok) && !busy;

	// The go write is held on the bus until the erase is over, which stalls the CPU.
	assign avs_waitrequest = (avs_read && !rd_wait) || (avs_write && (start || busy));
	wire wr_acc = avs_write && !avs_waitrequest;
	wire key_wr = wr_acc && sel_key && lane0;
	wire ctrl_wr = wr_acc && sel_ctrl && lane0;
	wire refuse = wr_acc && go_req && unlock == UL_KEY2;
	wire erase_end = busy && er_cnt == ROW_LAST;

	// Erase writes: one word of the latched program row per cycle, or the four ID words in the first four cycles; ones only.
	wire prog_we = busy && !er_space;
	wire id_we = busy && er_space && er_cnt[4:2] == 3'h0;
	assign cpu_stall = busy;
	assign op_done_irq = ctrl.done && ctrl.irq_en;

	// Read views of the registers.
	wire in_info = target >= INFO_FIRST && target <= INFO_LAST;
	wire [WORD_W-1:0] id_word = target <= ID_LAST ? id_rdata :
		target == REV_ADDR ? REV_ID_VAL :
		target == DEVID_ADDR ? DEV_ID_VAL : {WORD_W{1'b0}};
	wire [WORD_W-1:0] space_word = ctrl.space_sel ? (in_info ? {WORD_W{1'b0}} : id_word) :
		(target <= PROG_LAST ? prog_rdata : {WORD_W{1'b0}});
	wire [31:0] ctrl_view = {25'h000_0000, refused, ctrl.irq_en, ctrl.done, ctrl.space_sel,
		ctrl.row_erase, ctrl.prog_en, busy};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_view :
		sel_addr ? {17'h0_0000, target} :
		sel_data ? {18'h0_0000, space_word} : 32'h0000_0000;

	// Handshake tracker: each accepted write is a step, judged by where it lands and, on the key register, by its key value.
	always_comb
	begin
		next_unlock = unlock;
		if (start)
		begin
			next_unlock = UL_IDLE;
		end
		else if (wr_acc)
		begin
			if (key_wr && avs_writedata[7:0] == KEY_FIRST)
			begin
				next_unlock = UL_KEY1;
			end
			else if (key_wr && avs_writedata[7:0] == KEY_SECOND && unlock == UL_KEY1)
			begin
				next_unlock = UL_KEY2;
			end
			else
			begin
				next_unlock = UL_IDLE;
			end
		end
	end

	// Unlock state register.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			unlock <= UL_IDLE;
		else
			unlock <= next_unlock;
	end

	// Control bits; an erase never writes program enable and a finishing erase beats a clear of done.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl <= CTRL_RST;
		end
		else
		begin
			if (ctrl_wr)
			begin
				ctrl.prog_en <= avs_writedata[BIT_PROG_EN];
				ctrl.row_erase <= avs_writedata[BIT_ROW_ERASE];
				ctrl.space_sel <= avs_writedata[BIT_SPACE];
				ctrl.irq_en <= avs_writedata[BIT_IRQ_EN];
			end
			if (erase_end)
				ctrl.done <= 1'b1;
			else if (ctrl_wr && avs_writedata[BIT_DONE])
				ctrl.done <= 1'b0;
		end
	end

	// Next target address; the stores read ahead with it, so a data read right after an address write sees the new word.
	always_comb
	begin
		next_target = target;
		if (wr_acc && sel_addr && lane0)
			next_target[7:0] = avs_writedata[7:0];
		if (wr_acc && sel_addr && lane1)
			next_target[14:8] = avs_writedata[14:8];
	end

	// Target address pair, one byte lane per half.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			target <= TARGET_RST;
		end
		else
		begin
			target <= next_target;
		end
	end

	// Erase sequencer: latch the row and space at start, walk 32 words, then release.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy <= 1'b0;
			er_cnt <= 5'h00;
			er_row <= 7'h00;
			er_space <= 1'b0;
		end
		else if (start)
		begin
			busy <= 1'b1;
			er_cnt <= 5'h00;
			er_row <= target[11:5];
			er_space <= ctrl.space_sel;
		end
		else if (busy)
		begin
			er_cnt <= er_cnt + 5'h01;
			if (erase_end)
				busy <= 1'b0;
		end
	end

	// Refusal status: set by a dropped go after a good handshake, cleared by the next start.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			refused <= 1'b0;
		else if (refuse)
			refused <= 1'b1;
		else if (start)
			refused <= 1'b0;
	end

	// Every read takes one wait state so read data always leave a flip-flop.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_wait <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			rd_wait <= avs_read && !rd_wait;
			if (avs_read && !rd_wait)
				avs_readdata <= rd_mux;
		end
	end

	// Program space store.
	row_mem #(
		.AW(PROG_AW),
		.DW(WORD_W)
	) u_prog_mem (
		.core_clk(core_clk),
		.we(prog_we),
		.waddr({er_row, er_cnt}),
		.wdata(ERASED_WORD),
		.raddr(next_target[11:0]),
		.rdata(prog_rdata)
	);

	// User identification words.
	row_mem #(
		.AW(ID_AW),
		.DW(WORD_W)
	) u_id_mem (
		.core_clk(core_clk),
		.we(id_we),
		.waddr(er_cnt[1:0]),
		.wdata(ERASED_WORD),
		.raddr(next_target[1:0]),
		.rdata(id_rdata)
	);

endmodule : flash_row_erase_unlock_ctrl
`default_nettype wire

//--- src/row_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Single-port-write, registered-read word store for one flash space.
module row_mem #(
	parameter int unsigned AW = 12,
	parameter int unsigned DW = 14
) (
	input wire logic core_clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	logic [DW-1:0] cells [2**AW];

	// Write one word and read one word per cycle; the read sees the old word on a clash.
	always_ff @(posedge core_clk)
	begin
		if (we)
		begin
			cells[waddr] <= wdata;
		end
		rdata <= cells[raddr];
	end

endmodule : row_mem
`default_nettype wire
